// ===== core/fpb_pkg.sv
// Constants for the read-port bus-matching, swap, mailbox and parity block.
// Assumes a single 250 MHz clock and a 64-bit classic Wishbone register bus.
package fpb_pkg;
  localparam int DATA_W = 36;
  localparam int LANE_W = 9;
  localparam int LANES = 4;
  localparam int DEPTH = 64;
  localparam int BUS_W = 64;
  localparam int SEL_W = 8;

  localparam logic [5:0] OFF_CTRL = 6'h00;
  localparam logic [5:0] OFF_DATA = 6'h08;
  localparam logic [5:0] OFF_STAT = 6'h10;

  localparam int CTRL_WSEL_LOW = 0;
  localparam int CTRL_WSEL_HIGH = 1;
  localparam int CTRL_ENDIAN = 2;
  localparam int CTRL_SWAP_LOW = 3;
  localparam int CTRL_SWAP_HIGH = 4;
  localparam int CTRL_PGEN_RD = 5;
  localparam int CTRL_ODD = 6;
  localparam int CTRL_PGEN_WR = 7;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  localparam int STAT_PEF_RD = 0;
  localparam int STAT_PEF_WR = 1;
  localparam int STAT_EMPTY = 2;
  localparam int STAT_FULL = 3;
  localparam int STAT_REMAIN = 4;
  localparam int STAT_UNDER = 6;
  localparam int STAT_WIDTH = 7;
  localparam int STAT_ENDIAN = 9;
  localparam int STAT_SWAP = 10;

  // Width codes are {width_select_high, width_select_low}
  localparam logic [1:0] WIDTH_LONG = 2'h0;
  localparam logic [1:0] WIDTH_WORD = 2'h1;
  localparam logic [1:0] WIDTH_BYTE = 2'h2;
  localparam logic [1:0] WIDTH_MAIL = 2'h3;

  // Swap codes are {swap_select_high, swap_select_low}
  localparam logic [1:0] SWAP_NONE = 2'h0;
  localparam logic [1:0] SWAP_BYTE = 2'h1;
  localparam logic [1:0] SWAP_WORD = 2'h2;
  localparam logic [1:0] SWAP_BOTH = 2'h3;
endpackage

// ===== core/fpb_q_if.sv
// Carrier between the read-port logic and the long-word storage array.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface fpb_q_if #(
  parameter int W = 36
);
  logic wr;
  logic rd;
  logic [W-1:0] wdata;
  logic [W-1:0] rdata;
  logic empty;
  logic full;
  modport store (input wr, input rd, input wdata, output rdata, output empty, output full);
  modport user (output wr, output rd, output wdata, input rdata, input empty, input full);
endinterface

// ===== core/fpb_read_port.sv
// Read port of the long-word queue: width matching, byte swap, mailboxes, parity.
// Assumes write-port strobes come from already qualified logic on the same clock.
//
// The implementer's own choices: register access over Wishbone and the register offsets.
`timescale 1ns/1ps
module fpb_read_port #(
  parameter int DEPTH = fpb_pkg::DEPTH
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [5:0] wb_adr_i,
  input wire logic [fpb_pkg::SEL_W-1:0] wb_sel_i,
  input wire logic [fpb_pkg::BUS_W-1:0] wb_dat_i,
  output logic wb_ack_o,
  output logic [fpb_pkg::BUS_W-1:0] wb_dat_o,
  input wire logic [fpb_pkg::DATA_W-1:0] wp_data,
  input wire logic wp_write,
  input wire logic write_port_mail_select,
  input wire logic wp_mail_read,
  output logic [fpb_pkg::DATA_W-1:0] wp_rdata,
  output logic read_port_parity_error_n,
  output logic write_port_parity_error_n
);
  localparam int AW = $clog2(DEPTH);

  fpb_q_if #(.W(fpb_pkg::DATA_W)) q ();

  fpb_store #(.W(fpb_pkg::DATA_W), .DEPTH(DEPTH), .AW(AW)) u_store (
    .clock(clock),
    .rstn(rstn),
    .q(q)
  );

  logic ack_r;
  logic [63:0] dat_r;
  logic [7:0] ctrl_r;
  logic [1:0] width_q_r;
  logic endian_q_r;
  logic [1:0] applied_w_r;
  logic applied_e_r;
  logic new_size_r;
  logic [35:0] out_r;
  logic [35:0] aux_r;
  logic [35:0] mail_register_one_r;
  logic [35:0] mail_register_two_r;
  logic [35:0] wp_rdata_r;
  logic [1:0] idx_r;
  logic [1:0] remain_r;
  logic [1:0] swap_r;
  logic under_r;
  logic pef_rd_r;
  logic pef_wr_r;

  function automatic logic [35:0] swap_bytes(input logic [35:0] w, input logic [1:0] sw);
    case (sw)
      fpb_pkg::SWAP_BYTE: return {w[8:0], w[17:9], w[26:18], w[35:27]};
      fpb_pkg::SWAP_WORD: return {w[17:0], w[35:18]};
      fpb_pkg::SWAP_BOTH: return {w[26:18], w[35:27], w[8:0], w[17:9]};
      default: return w;
    endcase
  endfunction

  function automatic logic [35:0] gen_par(input logic [35:0] w, input logic odd);
    logic [35:0] o;
    o = w;
    for (int i = 0; i < fpb_pkg::LANES; i++) begin
      o[fpb_pkg::LANE_W*i+8] = (^w[fpb_pkg::LANE_W*i +: 8]) ^ odd;
    end
    return o;
  endfunction

  // Unused lanes read zero; callers must not depend on them
  function automatic logic [35:0] place(input logic [35:0] w, input logic [1:0] n, input logic [1:0] wd,
                                        input logic le);
    logic [35:0] o;
    o = '0;
    case (wd)
      fpb_pkg::WIDTH_WORD: begin
        if (le) begin
          o[17:0] = w[18*int'(n[0]) +: 18];
        end else begin
          o[35:18] = w[18*(1-int'(n[0])) +: 18];
        end
      end
      fpb_pkg::WIDTH_BYTE: begin
        if (le) begin
          o[8:0] = w[9*int'(n) +: 9];
        end else begin
          o[35:27] = w[9*(3-int'(n)) +: 9];
        end
      end
      default: o = w;
    endcase
    return o;
  endfunction

  function automatic logic [3:0] lane_mask(input logic [1:0] wd, input logic le);
    case (wd)
      fpb_pkg::WIDTH_WORD: return le ? 4'h3 : 4'hC;
      fpb_pkg::WIDTH_BYTE: return le ? 4'h1 : 4'h8;
      default: return 4'hF;
    endcase
  endfunction

  // Bus decode
  wire acc = wb_cyc_i & wb_stb_i & ~ack_r;
  wire acc_rd = acc & ~wb_we_i;
  wire acc_wr = acc & wb_we_i;
  wire hit_ctrl = wb_adr_i[5:3] == fpb_pkg::OFF_CTRL[5:3];
  wire hit_data = wb_adr_i[5:3] == fpb_pkg::OFF_DATA[5:3];
  wire hit_stat = wb_adr_i[5:3] == fpb_pkg::OFF_STAT[5:3];

  wire [1:0] width_c = {ctrl_r[fpb_pkg::CTRL_WSEL_HIGH], ctrl_r[fpb_pkg::CTRL_WSEL_LOW]};
  wire [1:0] swap_c = {ctrl_r[fpb_pkg::CTRL_SWAP_HIGH], ctrl_r[fpb_pkg::CTRL_SWAP_LOW]};
  wire pgb_c = ctrl_r[fpb_pkg::CTRL_PGEN_RD];
  wire pga_c = ctrl_r[fpb_pkg::CTRL_PGEN_WR];
  wire odd_c = ctrl_r[fpb_pkg::CTRL_ODD];
  // Mail decode uses the live selects so the mailbox answers at once
  wire mail_c = width_c == fpb_pkg::WIDTH_MAIL;

  wire mail_rd = acc_rd & hit_data & mail_c;
  wire mail_wr = acc_wr & hit_data & mail_c;
  wire q_read = acc_rd & hit_data & ~mail_c;
  wire need_new = (remain_r == 2'h0) | new_size_r;
  wire fetch = q_read & need_new & ~q.empty;
  wire step = q_read & ~need_new;
  wire underrun = q_read & need_new & q.empty;
  wire new_size_set = (width_q_r != fpb_pkg::WIDTH_MAIL) & (width_q_r != applied_w_r);

  wire [1:0] last_idx = (applied_w_r == fpb_pkg::WIDTH_BYTE) ? 2'h3 :
                        (applied_w_r == fpb_pkg::WIDTH_WORD) ? 2'h1 : 2'h0;

  // Swap before sequencing, parity made on the way into the output register
  wire [35:0] swapped = swap_bytes(q.rdata, swap_c);
  wire [35:0] fetched = pgb_c ? gen_par(swapped, odd_c) : swapped;
  wire [35:0] unit_src = fetch ? fetched : aux_r;
  wire [1:0] unit_idx = fetch ? 2'h0 : idx_r;
  wire [35:0] placed = place(unit_src, unit_idx, applied_w_r, applied_e_r);
  wire [35:0] out_nxt = (fetch | step) ? placed : out_r;
  // Mail data never passes the width or swap path
  wire [35:0] mail_out = pgb_c ? gen_par(mail_register_one_r, odd_c) : mail_register_one_r;

  wire [35:0] wmask = {{4{wb_sel_i[4]}}, {8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}},
                       {8{wb_sel_i[0]}}};
  wire [35:0] mail_register_two_nxt = (mail_register_two_r & ~wmask) | (wb_dat_i[35:0] & wmask);

  // Parity check on read-port traffic
  wire [35:0] chk_rd = mail_wr ? mail_register_two_nxt : (mail_rd ? mail_register_one_r : out_nxt);
  wire [3:0] mask_rd = (mail_wr | mail_rd) ? 4'hF : lane_mask(applied_w_r, applied_e_r);
  wire chk_rd_en = mail_wr | (mail_rd & ~pgb_c) | fetch | step;
  wire [35:0] chk_wr = wp_write ? wp_data : mail_register_two_r;
  wire [35:0] wp_out = pga_c ? gen_par(mail_register_two_r, odd_c) : mail_register_two_r;
  logic [3:0] bad_rd;
  logic [3:0] bad_wr;

  for (genvar i = 0; i < fpb_pkg::LANES; i++) begin : g_lane
    assign bad_rd[i] = mask_rd[i] & ((^chk_rd[fpb_pkg::LANE_W*i +: fpb_pkg::LANE_W]) != odd_c);
    assign bad_wr[i] = (^chk_wr[fpb_pkg::LANE_W*i +: fpb_pkg::LANE_W]) != odd_c;
  end

  logic [63:0] stat_w;
  always_comb begin
    stat_w = '0;
    stat_w[fpb_pkg::STAT_PEF_RD] = pef_rd_r;
    stat_w[fpb_pkg::STAT_PEF_WR] = pef_wr_r;
    stat_w[fpb_pkg::STAT_EMPTY] = q.empty;
    stat_w[fpb_pkg::STAT_FULL] = q.full;
    stat_w[fpb_pkg::STAT_REMAIN +: 2] = remain_r;
    stat_w[fpb_pkg::STAT_UNDER] = under_r;
    stat_w[fpb_pkg::STAT_WIDTH +: 2] = applied_w_r;
    stat_w[fpb_pkg::STAT_ENDIAN] = applied_e_r;
    stat_w[fpb_pkg::STAT_SWAP +: 2] = swap_r;
  end

  wire [63:0] rd_data = hit_ctrl ? {56'h0, ctrl_r} :
                        hit_data ? {28'h0, (mail_c ? mail_out : out_nxt)} :
                        hit_stat ? stat_w : 64'h0;
  wire under_clr = acc_wr & hit_stat & wb_sel_i[0] & wb_dat_i[fpb_pkg::STAT_UNDER];

  // Bus slave: one wait state, unmapped reads return zero
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ack_r <= 1'b0;
      dat_r <= '0;
      ctrl_r <= fpb_pkg::CTRL_RESET;
    end else begin
      ack_r <= acc;
      dat_r <= acc_rd ? rd_data : dat_r;
      if (acc_wr & hit_ctrl & wb_sel_i[0]) begin
        ctrl_r <= wb_dat_i[7:0];
      end
    end
  end

  // Selects are captured every edge; mail codes leave the applied width alone
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      width_q_r <= fpb_pkg::WIDTH_LONG;
      endian_q_r <= 1'b0;
      applied_w_r <= fpb_pkg::WIDTH_LONG;
      applied_e_r <= 1'b0;
    end else begin
      width_q_r <= width_c;
      endian_q_r <= ctrl_r[fpb_pkg::CTRL_ENDIAN];
      if (width_q_r != fpb_pkg::WIDTH_MAIL) begin
        applied_w_r <= width_q_r;
        applied_e_r <= endian_q_r;
      end
    end
  end

  // Sequence state; set wins over clear for the sticky flags
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      new_size_r <= 1'b0;
      idx_r <= 2'h0;
      remain_r <= 2'h0;
      swap_r <= fpb_pkg::SWAP_NONE;
      aux_r <= '0;
      out_r <= '0;
      under_r <= 1'b0;
    end else begin
      new_size_r <= new_size_set | (new_size_r & ~fetch);
      under_r <= underrun | (under_r & ~under_clr);
      out_r <= out_nxt;
      if (fetch) begin
        aux_r <= fetched;
        swap_r <= swap_c;
        idx_r <= 2'h1;
        remain_r <= last_idx;
      end else if (step) begin
        idx_r <= idx_r + 2'h1;
        remain_r <= remain_r - 2'h1;
      end
    end
  end

  // Mailboxes and parity flags
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      mail_register_one_r <= '0;
      mail_register_two_r <= '0;
      wp_rdata_r <= '0;
      pef_rd_r <= 1'b1;
      pef_wr_r <= 1'b1;
    end else begin
      if (wp_write & write_port_mail_select) begin
        mail_register_one_r <= wp_data;
      end
      if (mail_wr) begin
        mail_register_two_r <= mail_register_two_nxt;
      end
      if (wp_mail_read) begin
        wp_rdata_r <= wp_out;
      end
      if (mail_rd & pgb_c) begin
        pef_rd_r <= 1'b1;
      end else if (chk_rd_en) begin
        pef_rd_r <= ~|bad_rd;
      end
      if (wp_write) begin
        pef_wr_r <= ~|bad_wr;
      end else if (wp_mail_read) begin
        pef_wr_r <= pga_c ? 1'b1 : ~|bad_wr;
      end
    end
  end

  assign q.wr = wp_write & ~write_port_mail_select;
  assign q.wdata = wp_data;
  assign q.rd = fetch;

  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;
  assign wp_rdata = wp_rdata_r;
  assign read_port_parity_error_n = pef_rd_r;
  assign write_port_parity_error_n = pef_wr_r;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);

  sequence s_fetch_at(logic [1:0] wd);
    fetch && applied_w_r == wd;
  endsequence

  sequence s_mail_gen_read;
    mail_rd && pgb_c;
  endsequence

  sequence s_wp_gen_read;
    wp_mail_read && pga_c && !wp_write;
  endsequence

  a_long_whole: assert property (s_fetch_at(fpb_pkg::WIDTH_LONG) |=>
    out_r == $past(fetched) && remain_r == 2'h0)
    else $error("long fetch did not load whole word");
  a_byte_rest: assert property (s_fetch_at(fpb_pkg::WIDTH_BYTE) |=>
    remain_r == 2'h3 && idx_r == 2'h1 && aux_r == $past(fetched))
    else $error("byte fetch did not keep three bytes");
  a_fresh_fetch: assert property (q_read && new_size_r && !q.empty |=>
    idx_r == 2'h1 && remain_r == $past(last_idx) && aux_r == $past(fetched))
    else $error("new width read reused old word");
  a_swap_held: assert property (!fetch |=> $stable(swap_r))
    else $error("swap order changed inside a long word");
  a_size_apply: assert property ((width_c != fpb_pkg::WIDTH_MAIL) |-> ##2
    (applied_w_r == $past(width_c, 2)))
    else $error("width not applied two edges later");
  a_mail_keeps_size: assert property (width_q_r == fpb_pkg::WIDTH_MAIL |=> $stable(applied_w_r))
    else $error("mail access disturbed applied width");
  a_mail_one_read: assert property (mail_rd && !pgb_c |=>
    wb_ack_o && wb_dat_o[35:0] == $past(mail_register_one_r))
    else $error("mail one read returned wrong word");
  a_mail_two_store: assert property (mail_wr && wb_sel_i == 8'hFF |=> mail_register_two_r == $past(wb_dat_i[35:0]))
    else $error("mail two did not store all bits");
  a_pef_forced: assert property (s_mail_gen_read |=> read_port_parity_error_n)
    else $error("parity flag not forced high");
  a_mail_par_gen: assert property (s_mail_gen_read |=>
    wb_dat_o[8] == ((^$past(mail_register_one_r[7:0])) ^ $past(odd_c)) && wb_dat_o[7:0] == $past(mail_register_one_r[7:0]))
    else $error("mail parity bit wrong");
  // Narrow fetches put the first unit on the endian lanes; the other lanes read zero
  a_little_word: assert property (fetch && applied_w_r == fpb_pkg::WIDTH_WORD && applied_e_r |=>
    out_r[17:0] == $past(fetched[17:0]) && out_r[35:18] == 18'h0)
    else $error("little word fetch on wrong lanes");
  a_big_byte: assert property (fetch && applied_w_r == fpb_pkg::WIDTH_BYTE && !applied_e_r |=>
    out_r[35:27] == $past(fetched[35:27]) && out_r[26:0] == 27'h0)
    else $error("big byte fetch on wrong lanes");
  a_step_count: assert property (step |=>
    remain_r == $past(remain_r) - 2'h1 && idx_r == $past(idx_r) + 2'h1)
    else $error("narrow step did not advance");
  a_mail_keeps_out: assert property (mail_rd || mail_wr |=>
    out_r == $past(out_r) && remain_r == $past(remain_r) && idx_r == $past(idx_r))
    else $error("mail access disturbed queue sequence");
  a_mail_register_one_store: assert property (wp_write && write_port_mail_select |=>
    mail_register_one_r == $past(wp_data))
    else $error("mail one did not store all bits");
  a_wp_flag_forced: assert property (s_wp_gen_read |=> write_port_parity_error_n)
    else $error("write port parity flag not forced high");
  a_wp_par_gen: assert property (s_wp_gen_read |=>
    wp_rdata[8] == ((^$past(mail_register_two_r[7:0])) ^ $past(odd_c)) && wp_rdata[7:0] == $past(mail_register_two_r[7:0]))
    else $error("write port mail parity bit wrong");
endmodule

// ===== core/fpb_store.sv
// Long-word queue storage with show-ahead read data.
// Assumes the user never relies on a write while full or a read while empty.
`timescale 1ns/1ps
module fpb_store #(
  parameter int W = 36,
  parameter int DEPTH = 64,
  parameter int AW = 6
) (
  input wire logic clock,
  input wire logic rstn,
  fpb_q_if.store q
);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0] cnt_r;

  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

  // Blocked strobes are dropped here so the count can never overflow or underflow
  wire do_wr = q.wr & (cnt_r != FULL_CNT);
  wire do_rd = q.rd & (cnt_r != '0);

  assign q.rdata = mem[rp_r];
  assign q.empty = cnt_r == '0;
  assign q.full = cnt_r == FULL_CNT;

  always_ff @(posedge clock) begin
    if (do_wr) begin
      mem[wp_r] <= q.wdata;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      wp_r <= do_wr ? wp_r + 1'b1 : wp_r;
      rp_r <= do_rd ? rp_r + 1'b1 : rp_r;
      cnt_r <= cnt_r + (AW+1)'(do_wr) - (AW+1)'(do_rd);
    end
  end
endmodule

// ===== verif/fpb_read_port_tb_top.sv
// Bench for the read port: Wishbone tasks, write-port model, expected words.
// Assumes the core package, interface, store and read port are compiled first.
`timescale 1ns/1ps
module fpb_read_port_tb_top;
  localparam logic [5:0] DAT = fpb_pkg::OFF_DATA;
  localparam logic [1:0] LNG = fpb_pkg::WIDTH_LONG;
  localparam logic [1:0] WRD = fpb_pkg::WIDTH_WORD;
  localparam logic [1:0] BYT = fpb_pkg::WIDTH_BYTE;
  localparam logic [1:0] MBX = fpb_pkg::WIDTH_MAIL;
  localparam logic [35:0] W0 = 36'hA_5C31_E7B2;
  logic clock = 1'b0;
  logic rstn;
  logic cyc;
  logic stb;
  logic we;
  logic [5:0] adr;
  logic [7:0] sel;
  logic [63:0] wdat;
  logic ack;
  logic [63:0] rdat;
  logic [35:0] wpd;
  logic wpw;
  logic wms;
  logic wmr;
  logic [35:0] wprd;
  logic pef_rd_n;
  logic pef_wr_n;
  logic [63:0] q;
  logic [35:0] w;
  logic [35:0] w2;
  logic [35:0] mb;
  logic [1:0] wd;
  int errors = 0;
  int comparisons = 0;
  int cycles = 0;
  always #2 clock = ~clock;
  fpb_read_port i_dut (.clock(clock), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_ack_o(ack), .wb_dat_o(rdat), .wp_data(wpd),
    .wp_write(wpw), .write_port_mail_select(wms), .wp_mail_read(wmr), .wp_rdata(wprd),
    .read_port_parity_error_n(pef_rd_n), .write_port_parity_error_n(pef_wr_n));
  fpb_wp_model i_wp (.clock(clock), .wp_data(wpd), .wp_write(wpw), .write_port_mail_select(wms),
    .wp_mail_read(wmr));
  task automatic finish_test();
    if (errors == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Ceiling is many times the few hundred cycles the sequence needs
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors++;
      finish_test();
    end
  end
  task automatic chk_data(input logic [63:0] got, input logic [63:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %0t data %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_flag(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %0t flag %b expected %b", $time, got, exp);
    end
  endtask
  // Waits for ack with no assumed latency; request held until ack is seen
  task automatic bus(input logic wr, input logic [5:0] a, input logic [63:0] d);
    int n;
    n = 0;
    @(posedge clock);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= wr;
    adr <= a;
    sel <= 8'hFF;
    wdat <= d;
    @(posedge clock);
    while (ack !== 1'b1 && n < 100) begin
      @(posedge clock);
      n++;
    end
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n == 100) begin
      errors++;
      $display("mismatch %0t bus timeout", $time);
    end
  endtask
  task automatic rd_chk(input logic [5:0] a, input logic [35:0] e);
    bus(1'b0, a, 64'h0);
    chk_data(q, {28'h0, e});
  endtask
  task automatic cfg(input logic [1:0] z, input logic en, input logic [1:0] s, input logic [2:0] p);
    bus(1'b1, fpb_pkg::OFF_CTRL, {56'h0, p, s, en, z});
  endtask
  function automatic logic [35:0] fix(input logic [35:0] v, input logic o);
    for (int l = 0; l < 4; l++) begin
      v[9*l+8] = ^v[9*l +: 8] ^ o;
    end
    return v;
  endfunction
  function automatic logic [35:0] swp(input logic [35:0] v, input logic [1:0] s);
    case (s)
      fpb_pkg::SWAP_BYTE: return {v[8:0], v[17:9], v[26:18], v[35:27]};
      fpb_pkg::SWAP_WORD: return {v[17:0], v[35:18]};
      fpb_pkg::SWAP_BOTH: return {v[26:18], v[35:27], v[8:0], v[17:9]};
      default: return v;
    endcase
  endfunction
  function automatic logic [35:0] nar(input logic [35:0] v, input logic [1:0] z, input logic en, input int i);
    case (z)
      fpb_pkg::WIDTH_WORD: return en ? {18'h0, v[18*i +: 18]} : {v[35-18*i -: 18], 18'h0};
      fpb_pkg::WIDTH_BYTE: return en ? {27'h0, v[9*i +: 9]} : {v[35-9*i -: 9], 27'h0};
      default: return v;
    endcase
  endfunction
  initial begin
    rstn = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 6'h00;
    sel = 8'hFF;
    wdat = 64'h0;
    repeat (20) @(posedge clock);
    rstn <= 1'b1;
    @(posedge clock);
    chk_flag(pef_rd_n, 1'b1);
    chk_flag(pef_wr_n, 1'b1);
    rd_chk(fpb_pkg::OFF_CTRL, 36'h0);
    rd_chk(6'h38, 36'h0);
    for (int s = 0; s < 4; s++) begin
      w = fix(W0 + 36'(s), 1'b0);
      cfg(LNG, 1'b0, 2'(s), 3'h0);
      i_wp.put(1'b0, w);
      rd_chk(DAT, swp(w, 2'(s)));
    end
    chk_flag(pef_rd_n, 1'b1);
    chk_flag(pef_wr_n, 1'b1);
    // Each pass mixes width, endian and swap; the mid-word swap change must be ignored
    for (int k = 0; k < 4; k++) begin
      wd = k[1] ? BYT : WRD;
      w = fix(W0 ^ 36'(k * 111), 1'b0);
      cfg(wd, k[0], 2'(k), 3'h0);
      i_wp.put(1'b0, w);
      for (int i = 0; i < (k[1] ? 4 : 2); i++) begin
        if (i == 1) begin
          cfg(wd, k[0], ~2'(k), 3'h0);
        end
        rd_chk(DAT, nar(swp(w, 2'(k)), wd, k[0], i));
      end
    end
    w = fix(~W0, 1'b0);
    w2 = fix(W0 ^ 36'hF, 1'b0);
    cfg(BYT, 1'b0, 2'h0, 3'h0);
    i_wp.put(1'b0, w);
    i_wp.put(1'b0, w2);
    rd_chk(DAT, nar(w, BYT, 1'b0, 0));
    cfg(WRD, 1'b0, 2'h0, 3'h0);
    rd_chk(DAT, nar(w2, WRD, 1'b0, 0));
    i_wp.put(1'b0, w);
    mb = fix(W0, 1'b0) ^ 36'h100;
    i_wp.put(1'b1, mb);
    #1;
    chk_flag(pef_wr_n, 1'b0);
    cfg(MBX, 1'b0, 2'h1, 3'h0);
    rd_chk(DAT, mb);
    chk_flag(pef_rd_n, 1'b0);
    cfg(WRD, 1'b0, 2'h0, 3'h0);
    rd_chk(DAT, nar(w2, WRD, 1'b0, 1));
    cfg(MBX, 1'b0, 2'h0, 3'h1);
    rd_chk(DAT, fix(mb, 1'b0));
    chk_flag(pef_rd_n, 1'b1);
    cfg(MBX, 1'b0, 2'h0, 3'h0);
    rd_chk(DAT, mb);
    bus(1'b1, DAT, {28'h0, mb});
    i_wp.take();
    #1;
    chk_data({28'h0, wprd}, {28'h0, mb});
    chk_flag(pef_wr_n, 1'b0);
    cfg(MBX, 1'b0, 2'h0, 3'h4);
    i_wp.take();
    #1;
    chk_data({28'h0, wprd}, {28'h0, fix(mb, 1'b0)});
    chk_flag(pef_wr_n, 1'b1);
    cfg(LNG, 1'b0, 2'h0, 3'h2);
    rd_chk(DAT, w);
    chk_flag(pef_rd_n, 1'b0);
    cfg(WRD, 1'b0, 2'h0, 3'h3);
    i_wp.put(1'b0, W0);
    rd_chk(DAT, nar(fix(W0, 1'b1), WRD, 1'b0, 0));
    cfg(WRD, 1'b0, 2'h0, 3'h0);
    rd_chk(DAT, nar(fix(W0, 1'b1), WRD, 1'b0, 1));
    cfg(BYT, 1'b0, 2'h0, 3'h0);
    i_wp.put(1'b0, mb);
    for (int i = 0; i < 4; i++) begin
      rd_chk(DAT, nar(mb, BYT, 1'b0, i));
      chk_flag(pef_rd_n, 1'(i != 3));
    end
    // An empty queue read repeats the last unit and raises the sticky underrun bit
    rd_chk(DAT, nar(mb, BYT, 1'b0, 3));
    bus(1'b0, fpb_pkg::OFF_STAT, 64'h0);
    chk_flag(q[fpb_pkg::STAT_UNDER], 1'b1);
    chk_flag(q[fpb_pkg::STAT_EMPTY], 1'b1);
    bus(1'b1, fpb_pkg::OFF_STAT, 64'h40);
    bus(1'b0, fpb_pkg::OFF_STAT, 64'h0);
    chk_flag(q[fpb_pkg::STAT_UNDER], 1'b0);
    finish_test();
  end
endmodule

// ===== verif/fpb_wp_model.sv
// Write-port side model: queue pushes, mail one loads, mail two reads.
// Assumes the bench calls its tasks from one process on the shared clock.
`timescale 1ns/1ps
module fpb_wp_model (
  input wire logic clock,
  output logic [35:0] wp_data,
  output logic wp_write,
  output logic write_port_mail_select,
  output logic wp_mail_read
);
  initial begin
    wp_data = 36'h0;
    wp_write = 1'b0;
    write_port_mail_select = 1'b0;
    wp_mail_read = 1'b0;
  end
  // Released data shows the inverse so a stale word never looks valid
  task automatic put(input logic mb, input logic [35:0] d);
    @(posedge clock);
    wp_write <= 1'b1;
    write_port_mail_select <= mb;
    wp_data <= d;
    @(posedge clock);
    wp_write <= 1'b0;
    wp_data <= ~d;
  endtask
  task automatic take();
    @(posedge clock);
    wp_mail_read <= 1'b1;
    @(posedge clock);
    wp_mail_read <= 1'b0;
  endtask
endmodule
